// ==== hw/dcr_control_bank.sv ====
// Contract
// - Clear bit 2 leaves fail-safe.
// - Clear bit 1 clears all fault flags.
// - Clear bit 0 clears power-on flag.
// - Test bit 1 forces fail-safe.
// - Test bit 0 pulses error 50us.
// - Protect bit 2 guards dimming, resets zero.
// - Protect bit 1 guards setup, resets one.
// - Protect bit 0 guards current, resets one.
// - Reset bit 2 resets whole logic.
// - Reset bit 1 reloads from NVM.
// - Reset bit 0 restores register defaults.
// - Standby bit 0: zero enables pull-up.
// - Burn bit starts only in program state.
// - Program bit 0 enters program state.
`timescale 1ns/1ps
`default_nettype none

module dcr_control_bank
    import dcr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output dcr_cmd_t cmd,
    output logic full_logic_reset_cmd,
    output logic failsafe_active,
    output logic global_error_flag,
    output logic error_pin_o,
    output logic error_pin_oe,
    output logic dimming_write_protect,
    output logic setup_write_protect,
    output logic current_write_protect,
    output logic standby_pin_pullup_en,
    output logic nvm_program_state_enable
);

    // ==========================================================
    // Bus decode.
    dcr_state_t s_q;
    dcr_state_t s_d;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic idx_ok;
    logic [7:0] wbyte;
    logic ctrl_open;
    logic nvm_open;
    logic full_reset_wr;

    // Byte address is four times the register index.
    assign idx = paddr[9:2];
    assign idx_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                    (idx >= IDX_FAULT_CLEAR) && (idx <= IDX_BLOCK_STATUS);
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
    assign ctrl_open = (s_q.ctrl_cnt == 3'(CTRL_KEY_LEN));
    assign nvm_open = (s_q.nvm_cnt == 3'(NVM_KEY_LEN));
    // A full logic reset needs the control gate open, like the other protected bits.
    assign full_reset_wr = wr && idx_ok && (idx == IDX_REGISTER_RESET) && ctrl_open &&
                           wbyte[BIT_FULL_RESET];

    // Slave always answers in the first access cycle.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !idx_ok;

    // Advances a key matcher: restart on a wrong byte, retry it as first byte.
    function automatic logic [2:0] key_step(input logic [2:0] cnt, input logic [7:0] b,
                                            input logic [7:0] exp_b, input logic [7:0] first_b);
        if (b == exp_b) begin
            key_step = cnt + 3'h1;
        end else if (b == first_b) begin
            key_step = 3'h1;
        end else begin
            key_step = 3'h0;
        end
    endfunction

    // ==========================================================
    // Next-state logic.
    always_comb begin
        s_d = s_q;
        s_d.pulses = '0;
        s_d.full_reset = 1'b0;
        // Error pulse countdown.
        if (s_q.err_cnt != '0) begin
            s_d.err_cnt = s_q.err_cnt - 14'h1;
        end
        if (rd) begin
            s_d.prdata = '0;
            unique case (idx)
                IDX_WRITE_PROTECT: s_d.prdata[2:0] = s_q.wp;
                IDX_STANDBY_PULLUP: s_d.prdata[0] = s_q.standby_pullup_off;
                IDX_CONTROL_GATE: s_d.prdata[7:0] = s_q.ctrl_last;
                IDX_NVM_PROGRAM: s_d.prdata[0] = s_q.nvm_state;
                IDX_NVM_GATE: s_d.prdata[7:0] = s_q.nvm_last;
                IDX_BLOCK_STATUS: s_d.prdata[4:0] = {ctrl_open, nvm_open, s_q.err_cnt != '0,
                                                     s_q.global_err, s_q.mode == DCR_FAILSAFE};
                default: s_d.prdata = '0; // Command bits self-clear, read zero.
            endcase
        end
        if (wr && idx_ok) begin
            unique case (idx)
                IDX_FAULT_CLEAR: begin
                    if (wbyte[BIT_EXIT_FS]) begin
                        s_d.mode = DCR_NORMAL;
                        s_d.pulses.exit_failsafe_cmd = 1'b1;
                    end
                    if (wbyte[BIT_CLEAR_FAULTS]) begin
                        s_d.global_err = 1'b0;
                        s_d.pulses.clear_all_faults_cmd = 1'b1;
                    end
                    s_d.pulses.clear_poweron_flag_cmd = wbyte[BIT_CLEAR_POWERON];
                end
                IDX_TEST_FORCE: begin
                    if (ctrl_open && wbyte[BIT_ENTER_FS]) begin
                        s_d.mode = DCR_FAILSAFE;
                        s_d.pulses.enter_failsafe_cmd = 1'b1;
                    end
                    if (ctrl_open && wbyte[BIT_FORCE_ERR] && s_q.mode == DCR_NORMAL) begin
                        s_d.global_err = 1'b1;
                        s_d.err_cnt = 14'(ERR_PULSE_CYC);
                    end
                end
                IDX_WRITE_PROTECT: begin
                    if (ctrl_open) begin
                        s_d.wp = wbyte[2:0];
                    end
                end
                IDX_REGISTER_RESET: begin
                    if (ctrl_open) begin
                        s_d.pulses.restore_defaults_cmd = wbyte[BIT_RESTORE_DEF];
                        s_d.pulses.nvm_reload_cmd = wbyte[BIT_NVM_RELOAD];
                        if (wbyte[BIT_RESTORE_DEF]) begin
                            s_d.wp = WP_RESET;
                            s_d.standby_pullup_off = STANDBY_RESET;
                            s_d.nvm_state = NVM_STATE_RESET;
                        end
                    end
                end
                IDX_STANDBY_PULLUP: s_d.standby_pullup_off = wbyte[BIT_STANDBY_PIN];
                IDX_CONTROL_GATE: begin
                    s_d.ctrl_last = wbyte;
                    if (!ctrl_open) begin
                        s_d.ctrl_cnt = key_step(s_q.ctrl_cnt, wbyte, CTRL_KEY[s_q.ctrl_cnt[1:0]],
                                                CTRL_KEY[0]);
                    end else begin
                        s_d.ctrl_cnt = key_step(3'h0, wbyte, CTRL_KEY[0], CTRL_KEY[0]);
                    end
                end
                IDX_NVM_PROGRAM: begin
                    if (nvm_open) begin
                        s_d.nvm_state = wbyte[BIT_NVM_STATE];
                        s_d.pulses.nvm_burn_start = wbyte[BIT_NVM_BURN] && s_q.nvm_state;
                    end
                end
                IDX_NVM_GATE: begin
                    s_d.nvm_last = wbyte;
                    if (!nvm_open && s_q.nvm_cnt < 3'(NVM_KEY_LEN)) begin
                        s_d.nvm_cnt = key_step(s_q.nvm_cnt, wbyte, NVM_KEY[s_q.nvm_cnt],
                                               NVM_KEY[0]);
                    end else begin
                        s_d.nvm_cnt = key_step(3'h0, wbyte, NVM_KEY[0], NVM_KEY[0]);
                    end
                end
                default: s_d.prdata = s_q.prdata;
            endcase
        end
        // A full logic reset wins over every other update and closes both gates.
        if (full_reset_wr) begin
            s_d = STATE_RESET;
            s_d.full_reset = 1'b1;
        end
    end

    // ==========================================================
    // State register; the reset pin loads constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs.
    assign prdata = s_q.prdata;
    assign cmd = s_q.pulses;
    assign full_logic_reset_cmd = s_q.full_reset;
    assign failsafe_active = (s_q.mode == DCR_FAILSAFE);
    assign global_error_flag = s_q.global_err;
    assign error_pin_o = 1'b0;
    assign error_pin_oe = (s_q.err_cnt != '0);
    assign dimming_write_protect = s_q.wp[BIT_DIM_WP];
    assign setup_write_protect = s_q.wp[BIT_SETUP_WP];
    assign current_write_protect = s_q.wp[BIT_CURR_WP];
    assign standby_pin_pullup_en = !s_q.standby_pullup_off;
    assign nvm_program_state_enable = s_q.nvm_state;

endmodule // dcr_control_bank

`default_nettype wire

// ==== hw/dcr_pkg.sv ====
package dcr_pkg;

    // ==========================================================
    // Register offsets are word indices; the byte address is four times the index.
    localparam logic [7:0] IDX_FAULT_CLEAR = 8'h91;
    localparam logic [7:0] IDX_TEST_FORCE = 8'h92;
    localparam logic [7:0] IDX_WRITE_PROTECT = 8'h93;
    localparam logic [7:0] IDX_REGISTER_RESET = 8'h94;
    localparam logic [7:0] IDX_STANDBY_PULLUP = 8'h95;
    localparam logic [7:0] IDX_CONTROL_GATE = 8'h96;
    localparam logic [7:0] IDX_NVM_PROGRAM = 8'h97;
    localparam logic [7:0] IDX_NVM_GATE = 8'h98;
    // Status register of block state, placed after the documented map.
    localparam logic [7:0] IDX_BLOCK_STATUS = 8'h99;

    // ==========================================================
    // Field positions.
    localparam int BIT_EXIT_FS = 2;
    localparam int BIT_CLEAR_FAULTS = 1;
    localparam int BIT_CLEAR_POWERON = 0;
    localparam int BIT_ENTER_FS = 1;
    localparam int BIT_FORCE_ERR = 0;
    localparam int BIT_DIM_WP = 2;
    localparam int BIT_SETUP_WP = 1;
    localparam int BIT_CURR_WP = 0;
    localparam int BIT_FULL_RESET = 2;
    localparam int BIT_NVM_RELOAD = 1;
    localparam int BIT_RESTORE_DEF = 0;
    localparam int BIT_STANDBY_PIN = 0;
    localparam int BIT_NVM_BURN = 1;
    localparam int BIT_NVM_STATE = 0;

    // ==========================================================
    // Reset values.
    localparam logic [2:0] WP_RESET = 3'h3;
    localparam logic STANDBY_RESET = 1'b0;
    localparam logic NVM_STATE_RESET = 1'b0;

    // ==========================================================
    // Unlock byte sequences.
    localparam int CTRL_KEY_LEN = 4;
    localparam logic [7:0] CTRL_KEY [CTRL_KEY_LEN] = '{8'h43, 8'h4f, 8'h44, 8'h45};
    localparam int NVM_KEY_LEN = 6;
    localparam logic [7:0] NVM_KEY [NVM_KEY_LEN] = '{8'h00, 8'h04, 8'h02, 8'h09, 8'h02, 8'h09};

    // ==========================================================
    // Timing: error pulse width.
    localparam int CLK_MHZ = 250;
    localparam int ERR_PULSE_US = 50;
    localparam int ERR_PULSE_CYC = ERR_PULSE_US * CLK_MHZ;

    // ==========================================================
    // Block state.
    typedef enum logic {DCR_NORMAL, DCR_FAILSAFE} dcr_mode_t;

    // Command pulse outputs, one cycle each.
    typedef struct packed {
        logic clear_poweron_flag_cmd;
        logic clear_all_faults_cmd;
        logic exit_failsafe_cmd;
        logic enter_failsafe_cmd;
        logic restore_defaults_cmd;
        logic nvm_reload_cmd;
        logic nvm_burn_start;
    } dcr_cmd_t;

    // Every bit of state of the bank, registered as one word.
    typedef struct packed {
        logic [31:0] prdata;
        dcr_mode_t mode;
        logic [2:0] wp;
        logic standby_pullup_off;
        logic nvm_state;
        logic [2:0] ctrl_cnt;
        logic [2:0] nvm_cnt;
        logic [7:0] ctrl_last;
        logic [7:0] nvm_last;
        logic [13:0] err_cnt;
        logic global_err;
        dcr_cmd_t pulses;
        logic full_reset;
    } dcr_state_t;

    // State of the bank after the reset pin or after a full logic reset.
    localparam dcr_state_t STATE_RESET = '{prdata: 32'h0, mode: DCR_NORMAL, wp: WP_RESET,
                                           standby_pullup_off: STANDBY_RESET, nvm_state: NVM_STATE_RESET,
                                           ctrl_cnt: 3'h0, nvm_cnt: 3'h0, ctrl_last: 8'h00, nvm_last: 8'h00,
                                           err_cnt: 14'h0, global_err: 1'b0, pulses: '0, full_reset: 1'b0};

endpackage

// ==== tb/dcr_control_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench for the control register bank.
module dcr_control_bank_tb import dcr_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    dcr_cmd_t cmd;
    logic full_logic_reset_cmd, failsafe_active, global_error_flag, error_pin_o, error_pin_oe;
    logic dimming_write_protect, setup_write_protect, current_write_protect;
    logic standby_pin_pullup_en, nvm_program_state_enable;
    wire [2:0] wp = {dimming_write_protect, setup_write_protect, current_write_protect};
    int num_checks = 0;
    int n_fail = 0;
    int n;
    always #2 pclk = ~pclk;
    dcr_control_bank u_dcr_control_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .cmd, .full_logic_reset_cmd, .failsafe_active, .global_error_flag,
        .error_pin_o, .error_pin_oe, .dimming_write_protect, .setup_write_protect, .current_write_protect,
        .standby_pin_pullup_en, .nvm_program_state_enable);
    dcr_host_model u_dcr_host_model (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb);
    // Prints the counts and the verdict, then stops.
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Compares one value and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus access; a hung bus ends the run.
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        u_dcr_host_model.xfer(w, idx, d, rd);
        if (u_dcr_host_model.tmo) begin
            n_fail++;
            finish_test();
        end
        #1;
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk({wp, standby_pin_pullup_en, nvm_program_state_enable}, 5'h0e);
        acc(0, 8'h93, 0); chk(rd, 32'h3);
        acc(1, 8'h93, 8'h04); chk(wp, 3'h3);
        u_dcr_host_model.open_gate(8'h96, 48'h434f0045, 4); acc(1, 8'h93, 8'h04); chk(wp, 3'h3);
        u_dcr_host_model.open_gate(8'h96, 48'h434f4445, 4);
        acc(1, 8'h93, 8'h04); chk(wp, 3'h4);
        acc(1, 8'h95, 8'h01); chk(standby_pin_pullup_en, 0);
        acc(1, 8'h95, 8'h00); chk(standby_pin_pullup_en, 1);
        acc(1, 8'h92, 8'h02); chk({cmd.enter_failsafe_cmd, failsafe_active}, 2'h3);
        acc(1, 8'h92, 8'h01); chk({global_error_flag, error_pin_oe}, 2'h0);
        acc(1, 8'h91, 8'h04); chk({cmd.exit_failsafe_cmd, failsafe_active}, 2'h2);
        acc(0, 8'h91, 0); chk(rd, 32'h0);
        acc(1, 8'h92, 8'h01); chk({global_error_flag, error_pin_oe, error_pin_o}, 3'h6);
        n = 0;
        // Counts the cycles until the error pin is released.
        while (error_pin_oe === 1'b1 && n < 20000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(n, ERR_PULSE_CYC);
        // A pulse that never ends has been counted above and ends the run.
        if (n >= 20000) begin
            finish_test();
        end
        acc(0, 8'h99, 0); chk(rd, 32'h12);
        acc(0, 8'h96, 0); chk(rd, 32'h45);
        acc(1, 8'h91, 8'h02); chk({cmd.clear_all_faults_cmd, global_error_flag}, 2'h2);
        acc(1, 8'h91, 8'h01); chk(cmd.clear_poweron_flag_cmd, 1);
        acc(1, 8'h94, 8'h02); chk(cmd.nvm_reload_cmd, 1);
        acc(1, 8'h94, 8'h01); chk({cmd.restore_defaults_cmd, wp}, 4'hb);
        u_dcr_host_model.open_gate(8'h96, 48'h434f4445, 4);
        acc(1, 8'h95, 8'h01);
        acc(1, 8'h94, 8'h04); chk(full_logic_reset_cmd, 1);
        acc(1, 8'h93, 8'h04); chk({wp, standby_pin_pullup_en}, 4'h7);
        acc(1, 8'h97, 8'h01); chk(nvm_program_state_enable, 0);
        u_dcr_host_model.open_gate(8'h98, 48'h000402090209, 6);
        acc(1, 8'h97, 8'h02); chk({cmd.nvm_burn_start, nvm_program_state_enable}, 2'h0);
        acc(1, 8'h97, 8'h01); chk(nvm_program_state_enable, 1);
        acc(1, 8'h97, 8'h03); chk(cmd.nvm_burn_start, 1);
        acc(1, 8'h97, 8'h00); chk(nvm_program_state_enable, 0);
        acc(0, 8'h9a, 0); chk(u_dcr_host_model.err, 1);
        finish_test();
    end
endmodule // dcr_control_bank_tb
`default_nettype wire

// ==== tb/dcr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Host that reaches the bank over the register bus.
module dcr_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    logic err;
    logic tmo;
    // Bus idles until the first transfer.
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, err, tmo} = '0;
    end
    // One transfer after an idle edge; it holds until pready is seen high or 100 cycles have passed.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        tmo = pready !== 1'b1;
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Writes a key to a gate register, first byte in lane len-1 of k.
    task automatic open_gate(input logic [7:0] idx, input logic [47:0] k, input int len);
        logic [31:0] r;
        for (int i = len - 1; i >= 0; i--) xfer(1'b1, idx, k[8*i +: 8], r);
    endtask
endmodule // dcr_host_model
`default_nettype wire

// ==== tb/dcr_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker on the ports of the control bank.
module dcr_properties
    import dcr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire dcr_cmd_t cmd,
    input wire logic full_logic_reset_cmd,
    input wire logic failsafe_active,
    input wire logic global_error_flag,
    input wire logic error_pin_oe,
    input wire logic dimming_write_protect,
    input wire logic setup_write_protect,
    input wire logic current_write_protect,
    input wire logic standby_pin_pullup_en,
    input wire logic nvm_program_state_enable
);
    logic wr;
    logic fc;
    logic [2:0] wp;
    logic [13:0] hi_q;
    // Taken writes and the protect levels as one vector.
    assign wr = psel && penable && pwrite && pready && pstrb[0];
    assign fc = wr && paddr == 12'h244;
    assign wp = {dimming_write_protect, setup_write_protect, current_write_protect};
    // Counts the cycles that the error pin is driven low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= '0;
        end else begin
            hi_q <= error_pin_oe ? hi_q + 14'h1 : 14'h0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_exit_fs: assert property (fc && pwdata[2] |=> cmd.exit_failsafe_cmd && !failsafe_active)
        else $error("exit of fail-safe not seen");
    a_clear_faults: assert property (fc && pwdata[1] |=> cmd.clear_all_faults_cmd && !global_error_flag)
        else $error("fault clear not seen");
    a_enter_fs: assert property ($rose(failsafe_active) |-> $past(wr && paddr == 12'h248 && pwdata[1]))
        else $error("fail-safe entered without command");
    a_err_start: assert property ($rose(error_pin_oe) |-> $past(wr && paddr == 12'h248 && pwdata[0] && !failsafe_active))
        else $error("error pulse without command");
    a_err_width: assert property ($fell(error_pin_oe) |-> hi_q == ERR_PULSE_CYC)
        else $error("error pulse width wrong");
    a_reset_levels: assert property ($rose(presetn) |-> wp == WP_RESET && standby_pin_pullup_en && !nvm_program_state_enable)
        else $error("levels after reset wrong");
    a_wp_cause: assert property (!$stable(wp) |-> $past(wr && (paddr == 12'h24c || paddr == 12'h250)))
        else $error("protect changed without write");
    a_standby_pin: assert property (wr && paddr == 12'h254 |=> standby_pin_pullup_en == !$past(pwdata[0]))
        else $error("pull-up control wrong");
    a_burn_state: assert property (cmd.nvm_burn_start |-> $past(nvm_program_state_enable))
        else $error("burn outside program state");
    a_pulse_once: assert property ({cmd, full_logic_reset_cmd} != 8'h0 |=> {cmd, full_logic_reset_cmd} == 8'h0)
        else $error("command pulse not self-clearing");
    c_err_pulse: cover property ($fell(error_pin_oe));
    c_failsafe: cover property ($rose(failsafe_active));
    c_burn: cover property (cmd.nvm_burn_start);
endmodule // dcr_properties

bind dcr_control_bank dcr_properties u_dcr_properties (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .cmd, .full_logic_reset_cmd, .failsafe_active, .global_error_flag, .error_pin_oe,
    .dimming_write_protect, .setup_write_protect, .current_write_protect, .standby_pin_pullup_en,
    .nvm_program_state_enable);
`default_nettype wire
